//--- bench/jlc_far_model.sv
// Far-side protocol handler model: finishes transfers and delivers messages.
module jlc_far_model (
  input wire logic clk_sys,
  input wire logic tx_start,
  input wire logic tx_abort_req,
  input wire logic rx_go,
  input wire logic [3:0] rx_go_len,
  output logic tx_crc_sent = 1'b0,
  output logic tx_end = 1'b0,
  output logic tx_abort_done = 1'b0,
  output logic rx_msg_ok = 1'b0,
  output logic [3:0] rx_msg_len = 4'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  int busy = 0;

  always @(posedge clk_sys) begin
    busy <= tx_start ? 20 : (busy > 0 ? busy - 1 : 0);
    tx_crc_sent <= (busy == 2);
    tx_end <= (busy == 1);
    tx_abort_done <= tx_abort_req && !tx_abort_done;
    rx_msg_ok <= rx_go;
    // Length is only meaningful with the strobe, so it churns otherwise.
    rx_msg_len <= rx_go ? rx_go_len : ~rx_msg_len;
  end
endmodule // jlc_far_model

//--- bench/jlc_regs_sva.sv
// Port assertions for the link controller register block.
module jlc_regs_sva (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cpu_wait,
  input wire logic cpu_stop,
  input wire logic tx_end,
  input wire logic core_clk_run,
  input wire logic tx_start,
  input wire logic [3:0] tx_len,
  input wire logic tx_len_error,
  input wire logic tx_abort_req,
  input wire logic rx_buf_release
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  sequence s_cnt_wr;
    reg_wr && reg_addr == 8'h10;
  endsequence
  sequence s_cnt_ok;
    s_cnt_wr ##0 reg_wdata[3:0] inside {[4'h1:4'hb]};
  endsequence

  tx_go_a: assert property (
    s_cnt_ok |=> tx_start && tx_len == $past(reg_wdata[3:0]))
    else $error("valid count did not start a transfer");
  tx_bad_a: assert property (
    s_cnt_wr ##0 !(reg_wdata[3:0] inside {[4'h1:4'hb]}) |=> tx_len_error && !tx_start)
    else $error("invalid count was not refused");
  len_clear_a: assert property (tx_end && !reg_wr |=> tx_len == 4'h0)
    else $error("count not cleared at transfer end");
  sts_read_a: assert property (reg_rd && reg_addr == 8'h0f |=> (reg_rdata & 8'hf3) == 8'h00)
    else $error("status spare bits not zero");
  cnt_read_a: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata[7:4] == 4'h0)
    else $error("count upper bits not zero");
  start_cause_a: assert property (tx_start |-> $past(reg_wr && reg_addr == 8'h10))
    else $error("start without count write");
  rel_cause_a: assert property (rx_buf_release |-> $past(reg_wr && reg_addr == 8'h11))
    else $error("release without receive count write");
  abort_cause_a: assert property ($rose(tx_abort_req) |-> $past(reg_wr && reg_wdata[6]))
    else $error("abort request rose without a write");
  run_clock_a: assert property ((!cpu_wait && !cpu_stop)[*3] |-> core_clk_run)
    else $error("core clock stopped outside wait or stop");
endmodule // jlc_regs_sva

bind j1850_link_cpu_regs jlc_regs_sva jlc_regs_sva_inst (
  .clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_wait,
  .cpu_stop, .tx_end, .core_clk_run, .tx_start, .tx_len, .tx_len_error, .tx_abort_req,
  .rx_buf_release
);

//--- bench/tb_top.sv
// Self-checking bench for the link controller register block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, osc_tick = 1'b0;
  logic cpu_wait = 1'b0, cpu_stop = 1'b0, net_activity = 1'b0, rx_msg_error = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic rx_go = 1'b0, rd_d = 1'b0;
  logic [3:0] rx_go_len = 4'h0, rx_msg_len, tx_len;
  logic tx_crc_sent, tx_end, tx_abort_done, rx_msg_ok, link_clk_en, core_clk_run, tx_start;
  logic tx_len_error, tx_abort_req, rx_long_msg, rx_buf_release, irq;
  logic [7:0] exp_q[$];
  int miscompares = 0, checks = 0;

  j1850_link_cpu_regs j1850_link_cpu_regs_inst (.clk_sys, .srst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .osc_tick, .cpu_wait, .cpu_stop, .net_activity,
    .tx_crc_sent, .tx_end, .tx_abort_done, .rx_msg_ok, .rx_msg_len, .rx_msg_error,
    .link_clk_en, .core_clk_run, .tx_start, .tx_len, .tx_len_error, .tx_abort_req,
    .rx_long_msg, .rx_buf_release, .irq);
  jlc_far_model jlc_far_model_inst (.clk_sys, .tx_start, .tx_abort_req, .rx_go, .rx_go_len,
    .tx_crc_sent, .tx_end, .tx_abort_done, .rx_msg_ok, .rx_msg_len);

  always #5 clk_sys = ~clk_sys;

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read data stands only in the cycle after the strobe.
  always @(posedge clk_sys) begin
    osc_tick <= 1'($urandom);
    rd_d <= reg_rd;
    if (rd_d) cmp(reg_rdata, exp_q.pop_front());
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
  endtask

  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    logic [3:0] n, m;
    void'($urandom(32'h6136));
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rd(8'h0e, 8'h20);
    rd(8'h0f, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h0e, 8'h13);
    rd(8'h0e, 8'h13);
    wr(8'h0e, 8'h20);
    rd(8'h0e, 8'h11);
    wr(8'h0e, 8'h02);
    wr(8'h0f, 8'hff);
    rd(8'h0f, 8'h00);
    n = 4'($urandom_range(11, 1));
    wr(8'h10, {4'($urandom), n});
    rd(8'h10, {4'h0, n});
    idle(25);
    rd(8'h0f, 8'h08);
    cmp({7'h0, irq}, 8'h01);
    rd(8'h10, 8'h00);
    rd(8'h0f, 8'h00);
    idle(3);
    cmp({7'h0, irq}, 8'h00);
    // Zero and counts past the buffer end are refused.
    for (int i = 11; i < 16; i++) begin
      wr(8'h10, 8'(i == 11 ? 0 : i));
      rd(8'h10, 8'h00);
    end
    wr(8'h0e, 8'h82);
    rd(8'h0e, 8'h93);
    // The read strobe must drop before the message burst.
    idle(1);
    n = 4'($urandom_range(11, 1));
    m = 4'($urandom_range(11, 1));
    rx_go_len <= n;
    rx_go <= 1'b1;
    @(posedge clk_sys);
    rx_go_len <= m;
    @(posedge clk_sys);
    rx_go <= 1'b0;
    idle(3);
    cmp({7'h0, irq}, 8'h01);
    rd(8'h0f, 8'h04);
    rd(8'h11, {4'h0, n});
    wr(8'h11, 8'h00);
    rd(8'h0f, 8'h04);
    cmp({7'h0, rx_buf_release}, 8'h01);
    rd(8'h11, {4'h0, m});
    wr(8'h11, 8'hff);
    rd(8'h0f, 8'h00);
    cmp({7'h0, rx_buf_release}, 8'h01);
    rd(8'h0e, 8'h13);
    wr(8'h0e, 8'h42);
    idle(4);
    rd(8'h0e, 8'h13);
    wr(8'h0e, 8'h00);
    wr(8'h10, 8'h01);
    idle(25);
    cmp({7'h0, irq}, 8'h00);
    rd(8'h0f, 8'h08);
    // The wait-stop bit is locked set, so a CPU wait parks the link clocks.
    cpu_wait <= 1'b1;
    idle(3);
    cmp({6'h0, link_clk_en, core_clk_run}, 8'h00);
    net_activity <= 1'b1;
    idle(5);
    cmp({7'h0, irq}, 8'h01);
    cpu_wait <= 1'b0;
    net_activity <= 1'b0;
    idle(2);
    cmp({6'h0, link_clk_en, core_clk_run}, 8'h03);
    rd(8'h0f, 8'h08);
    wr(8'h11, 8'h00);
    idle(3);
    cmp({7'h0, irq}, 8'h00);
    test_done();
  end

  // The sequence needs about 125 cycles, so 20 us means a hang.
  initial begin
    #20000;
    miscompares++;
    test_done();
  end
endmodule // tb_top

//--- verilog/j1850_link_cpu_regs.sv
// CPU-facing control, status and count registers of the J1850 message data link controller.
//
// Chosen here: the plain strobed port.
`include "jlc_defs.svh"

module j1850_link_cpu_regs
  import jlc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic osc_tick,
  input wire logic cpu_wait,
  input wire logic cpu_stop,
  input wire logic net_activity,
  input wire logic tx_crc_sent,
  input wire logic tx_end,
  input wire logic tx_abort_done,
  input wire logic rx_msg_ok,
  input wire logic [3:0] rx_msg_len,
  input wire logic rx_msg_error,
  output logic link_clk_en,
  output logic core_clk_run,
  output logic tx_start,
  output logic [3:0] tx_len,
  output logic tx_len_error,
  output logic tx_abort_req,
  output logic rx_long_msg,
  output logic rx_buf_release,
  output logic irq
);

  logic ctl_locked;
  logic [1:0] rate_sel;
  logic irq_enable;
  logic wait_clock_stop;
  logic tx_done_flag;
  logic rx_done_flag;
  logic wake_pend;
  jlc_mode_type mode;
  jlc_mode_type next_mode;
  logic [1:0] rx_held;
  jlc_len_type rx_len_old;
  jlc_len_type rx_len_new;
  logic net_meta;
  logic net_sync;
  logic link_tick;
  logic ctl_wr;
  logic tx_acc;
  logic tx_wr;
  logic rx_acc;
  logic rx_wr;
  logic len_valid;
  logic rx_take;
  logic rx_release;
  logic wake_event;

  // Kept whole so that the two-bit rate field is cut out of it on purpose.
  localparam logic [7:0] ctl_reset_value = `JLC_CTL_RESET;

  assign ctl_wr = reg_wr && (reg_addr == `JLC_ADDR_CONTROL);
  assign tx_acc = (reg_wr || reg_rd) && (reg_addr == `JLC_ADDR_TX_COUNT);
  assign tx_wr = reg_wr && (reg_addr == `JLC_ADDR_TX_COUNT);
  assign rx_acc = (reg_wr || reg_rd) && (reg_addr == `JLC_ADDR_RX_COUNT);
  assign rx_wr = reg_wr && (reg_addr == `JLC_ADDR_RX_COUNT);
  // A third message with both buffers full is ignored.
  assign rx_take = rx_msg_ok && (rx_held != 2'h2);
  // A release with nothing held is ignored, so the queue cannot underflow.
  assign rx_release = rx_wr && (rx_held != 2'h0);
  assign wake_event = (mode == JLC_LINK_STOP && net_sync) || (mode == JLC_LINK_WAIT && rx_take);
  assign len_valid = (reg_wdata[3:0] >= `JLC_TX_LEN_MIN) && (reg_wdata[3:0] <= `JLC_TX_LEN_MAX);

  // The activity pin is asynchronous to the system clock.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      net_meta <= 1'b0;
      net_sync <= 1'b0;
    end else begin
      net_meta <= net_activity;
      net_sync <= net_meta;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctl_locked <= 1'b0;
      rate_sel <= ctl_reset_value[`JLC_CTL_RATE_HI:`JLC_CTL_RATE_LO];
      wait_clock_stop <= 1'b0;
    end else if (ctl_wr && !ctl_locked) begin
      ctl_locked <= 1'b1;
      rate_sel <= {reg_wdata[`JLC_CTL_RATE_HI], reg_wdata[`JLC_CTL_RATE_LO]};
      wait_clock_stop <= reg_wdata[`JLC_CTL_WAIT_STOP];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_enable <= 1'b0;
    end else if (ctl_wr) begin
      irq_enable <= reg_wdata[`JLC_CTL_IRQ_EN];
    end
  end

  // abort set by CPU, cleared by controller
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_abort_req <= 1'b0;
    end else if (ctl_wr && reg_wdata[`JLC_CTL_ABORT]) begin
      tx_abort_req <= 1'b1;
    end else if (tx_abort_done) begin
      tx_abort_req <= 1'b0;
    end
  end

  // Long-message mode ends with a good message or any receive error.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_long_msg <= 1'b0;
    end else if (ctl_wr && reg_wdata[`JLC_CTL_LONG_MSG]) begin
      rx_long_msg <= 1'b1;
    end else if (rx_msg_ok || rx_msg_error) begin
      rx_long_msg <= 1'b0;
    end
  end

  jlc_rate_div u_rate_div (
    .clk_sys(clk_sys),
    .srst(srst),
    .osc_tick(osc_tick),
    .rate_sel(rate_sel),
    .link_tick(link_tick)
  );

  // The run level is taken from the next mode so it matches the mode register.
  // link clock stops in stop mode
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link_clk_en <= 1'b0;
      core_clk_run <= 1'b1;
    end else begin
      link_clk_en <= link_tick && (mode != JLC_LINK_STOP);
      core_clk_run <= (next_mode != JLC_LINK_STOP);
    end
  end

  // Only network activity ends link stop early; a good message ends link wait.
  // wait-stop bit picks the low power mode
  always_comb begin
    next_mode = mode;
    case (mode)
      JLC_RUN: begin
        if (cpu_stop || (cpu_wait && wait_clock_stop)) begin
          next_mode = JLC_LINK_STOP;
        end else if (cpu_wait) begin
          next_mode = JLC_LINK_WAIT;
        end
      end
      JLC_LINK_WAIT: begin
        if (rx_take || !cpu_wait) begin
          next_mode = JLC_RUN;
        end
      end
      JLC_LINK_STOP: begin
        if (net_sync || !(cpu_wait || cpu_stop)) begin
          next_mode = JLC_RUN;
        end
      end
      default: next_mode = JLC_RUN;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode <= JLC_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // wake request set by a wake-up, cleared by receive count access
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wake_pend <= 1'b0;
    end else if (wake_event) begin
      wake_pend <= 1'b1;
    end else if (rx_acc) begin
      wake_pend <= 1'b0;
    end
  end

  // A refused write still clears the count, so a stale length is never started later.
  // four-bit count, start, cleared at end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_len <= 4'h0;
    end else if (tx_wr && len_valid) begin
      tx_len <= reg_wdata[3:0];
    end else if (tx_end || tx_wr) begin
      tx_len <= 4'h0;
    end
  end

  // out of range count raises an overflow and is not sent
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_start <= 1'b0;
      tx_len_error <= 1'b0;
    end else begin
      tx_start <= tx_wr && len_valid;
      tx_len_error <= tx_wr && !len_valid;
    end
  end

  // set on CRC sent; access clears; set wins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_done_flag <= 1'b0;
    end else if (tx_crc_sent) begin
      tx_done_flag <= 1'b1;
    end else if (tx_acc) begin
      tx_done_flag <= 1'b0;
    end
  end

  // A release and a new message in one cycle leave the number held unchanged.
  // held-message queue; oldest is presented
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_held <= 2'h0;
      rx_len_old <= 4'h0;
      rx_len_new <= 4'h0;
    end else begin
      case ({rx_take, rx_release})
        2'b10: begin
          rx_held <= rx_held + 2'h1;
          if (rx_held == 2'h0) begin
            rx_len_old <= rx_msg_len;
          end else begin
            rx_len_new <= rx_msg_len;
          end
        end
        2'b01: begin
          rx_held <= rx_held - 2'h1;
          rx_len_old <= rx_len_new;
        end
        2'b11: begin
          if (rx_held == 2'h1) begin
            rx_len_old <= rx_msg_len;
          end else begin
            rx_len_old <= rx_len_new;
            rx_len_new <= rx_msg_len;
          end
        end
        default: rx_held <= rx_held;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_buf_release <= 1'b0;
    end else begin
      rx_buf_release <= rx_release;
    end
  end

  // receive flag; a new message or a second held one keeps it set
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_done_flag <= 1'b0;
    end else if (rx_take) begin
      rx_done_flag <= 1'b1;
    end else if (rx_acc) begin
      rx_done_flag <= (rx_held == 2'h2);
    end
  end

  // The request is registered, so it trails the flags by one cycle.
  // single request line
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= (irq_enable && (tx_done_flag || rx_done_flag)) || wake_pend;
    end
  end

  // Read data return to zero outside the answer cycle, so a late sample reads zero.
  // registered read data
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `JLC_ADDR_CONTROL: begin
          reg_rdata <= {rx_long_msg, tx_abort_req, rate_sel, 2'b00, irq_enable,
            wait_clock_stop};
        end
        `JLC_ADDR_STATUS: begin
          reg_rdata <= {4'h0, tx_done_flag, rx_done_flag, 2'b00};
        end
        `JLC_ADDR_TX_COUNT: reg_rdata <= {4'h0, tx_len};
        `JLC_ADDR_RX_COUNT: reg_rdata <= {4'h0, rx_len_old};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // j1850_link_cpu_regs

//--- verilog/jlc_defs.svh
// Register offsets, field positions, reset values and limits of the link controller.
`ifndef JLC_DEFS_SVH
`define JLC_DEFS_SVH

`define JLC_ADDR_CONTROL 8'h0e
`define JLC_ADDR_STATUS 8'h0f
`define JLC_ADDR_TX_COUNT 8'h10
`define JLC_ADDR_RX_COUNT 8'h11

`define JLC_CTL_LONG_MSG 7
`define JLC_CTL_ABORT 6
`define JLC_CTL_RATE_HI 5
`define JLC_CTL_RATE_LO 4
`define JLC_CTL_IRQ_EN 1
`define JLC_CTL_WAIT_STOP 0
`define JLC_CTL_RESET 8'h20

`define JLC_STS_TX_DONE 3
`define JLC_STS_RX_DONE 2

`define JLC_TX_LEN_MAX 4'hb
`define JLC_TX_LEN_MIN 4'h1

`define JLC_RATE_OSC 2'h0
`define JLC_RATE_DIV1 2'h1
`define JLC_RATE_DIV2 2'h2
`define JLC_RATE_DIV4 2'h3

`endif

//--- verilog/jlc_pkg.sv
// Types shared by the link controller register logic.
package jlc_pkg;

  typedef enum logic [1:0] {
    JLC_RUN,
    JLC_LINK_WAIT,
    JLC_LINK_STOP
  } jlc_mode_type;

  typedef logic [3:0] jlc_len_type;

endpackage

//--- verilog/jlc_rate_div.sv
// Rate divider that turns a source clock enable into the link clock enable.
`include "jlc_defs.svh"

module jlc_rate_div
  import jlc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic osc_tick,
  input wire logic [1:0] rate_sel,
  output logic link_tick
);

  logic src_tick;
  logic [1:0] div_cnt;
  logic last_count;

  always_comb begin
    if (rate_sel == `JLC_RATE_OSC) begin
      src_tick = osc_tick;
    end else begin
      src_tick = 1'b1;
    end
  end

  // divide by one, two or four
  always_comb begin
    case (rate_sel)
      `JLC_RATE_DIV2: last_count = (div_cnt[0] == 1'b1);
      `JLC_RATE_DIV4: last_count = (div_cnt == 2'h3);
      default: last_count = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_cnt <= 2'h0;
    end else if (src_tick) begin
      div_cnt <= last_count ? 2'h0 : div_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link_tick <= 1'b0;
    end else begin
      link_tick <= src_tick & last_count;
    end
  end

endmodule // jlc_rate_div
